// ### logic/bmd_pkg.sv
/*
  Package for the buffer manager drop statistics and discard table block:
  register indices, field positions, reset values, timing constants, carriers.
  Assumes a 32-bit Avalon-MM slave whose word address is the register index.
*/
package bmd_pkg;

  // ---------------------------------------------------------------
  // Register map (word indices, byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [12:0] BMD_IDX_PORT1_DROP = 13'h 1c06;
  localparam logic [12:0] BMD_IDX_PORT2_DROP = 13'h 1c07;
  localparam logic [12:0] BMD_IDX_INIT_STATUS = 13'h 1c08;
  localparam logic [12:0] BMD_IDX_TABLE_CMD = 13'h 1c09;
  localparam logic [12:0] BMD_IDX_TABLE_WDATA = 13'h 1c0a;
  localparam logic [12:0] BMD_IDX_TABLE_RDATA = 13'h 1c0b;
  localparam logic [12:0] BMD_IDX_BASE = 13'h 1c00;
  localparam int BMD_ADDR_W = 15;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int BMD_CMD_DIR_BIT = 4;
  localparam int BMD_CMD_IDX_MSB = 3;
  localparam int BMD_PROB_W = 10;
  localparam int BMD_TABLE_DEPTH = 16;
  localparam int BMD_READY_BIT = 0;
  localparam logic [31:0] BMD_CNT_RESET = 32'h 0000_0000;
  localparam logic [31:0] BMD_CNT_MAX = 32'h ffff_ffff;
  localparam logic [4:0] BMD_CMD_RESET = 5'h 00;
  localparam logic [9:0] BMD_PROB_RESET = 10'h 000;

  // ---------------------------------------------------------------
  // Timing: table initialisation counts BMD_INIT_CYCLES core clock cycles
  // ---------------------------------------------------------------
  localparam int BMD_CLK_PERIOD_PS = 5000;
  localparam int BMD_INIT_CYCLES = 64;
  localparam logic [6:0] BMD_INIT_COUNT = 7'(BMD_INIT_CYCLES);

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [BMD_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } bmd_req_t;

  typedef struct packed {
    logic buffer_full;   // Dropped for lack of buffer space
    logic meter_red;     // Dropped as red by the ingress meter
    logic meter_yellow;  // Dropped as random yellow discard
  } bmd_drop_t;

  typedef enum logic [1:0] {
    BMD_ST_INIT = 2'b00,
    BMD_ST_READY = 2'b01
  } bmd_state_t;

endpackage : bmd_pkg

// ### logic/bmd_drop_counter.sv
/*
  One saturating clear-on-read drop counter.
  Assumes drop events and the clear strobe are on the core clock.
*/
`timescale 1ns/1ps
module bmd_drop_counter
  import bmd_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire bmd_drop_t drop,
  input wire logic clear,
  output logic [31:0] count
);

  // ---------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------
  // Any drop cause counts once per event
  wire logic hit = drop.buffer_full | drop.meter_red | drop.meter_yellow; // [R3]
  wire logic at_max = (count == BMD_CNT_MAX);
  // A drop in the read cycle is kept as the new count of one
  wire logic [31:0] next_count = clear ? {31'h 0, hit} : // [R4]
                                 (hit && !at_max) ? count + 32'h 1 : count; // [R5]

  // Counter register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count <= BMD_CNT_RESET; // [R4]
    end else begin
      count <= next_count;
    end
  end

  a_sat_hold: assert property (@(posedge clock) disable iff (!arst_n) // [R5]
    (at_max && !clear) |=> (count == BMD_CNT_MAX))
    else $error("Counter left saturation without a read");

  a_clear_read: assert property (@(posedge clock) disable iff (!arst_n) // [R4]
    (clear && !hit) |=> (count == 32'h 0))
    else $error("Counter not cleared by read");

  a_count_step: assert property (@(posedge clock) disable iff (!arst_n) // [R3]
    (hit && !clear && !at_max) |=> (count == $past(count) + 32'h 1))
    else $error("Drop did not advance the counter");

endmodule : bmd_drop_counter

// ### logic/bmd_weight_table.sv
/*
  Sixteen-entry random discard weight store with one write port and two read ports.
  Assumes index and data are stable for the cycle of the strobe.
*/
`timescale 1ns/1ps
module bmd_weight_table
  import bmd_pkg::*;
(
  input wire logic clock,
  input wire logic write_en,
  input wire logic [3:0] write_index,
  input wire logic [9:0] write_prob,
  input wire logic [3:0] read_index,
  output logic [9:0] read_prob,
  input wire logic [3:0] usage_index,
  output logic [9:0] usage_prob
);

  // ---------------------------------------------------------------
  // Storage, not reset: software loads every entry
  // ---------------------------------------------------------------
  logic [BMD_PROB_W-1:0] entry [BMD_TABLE_DEPTH];

  // Write port
  always_ff @(posedge clock) begin
    if (write_en) begin
      entry[write_index] <= write_prob; // [R14]
    end
  end

  // Read ports
  assign read_prob = entry[read_index];
  assign usage_prob = entry[usage_index];

endmodule : bmd_weight_table

// ### logic/bmd_regs.sv
/*
  Register bank of the buffer manager: port 1 and port 2 drop counters,
  initialisation ready flag and the indirect random discard weight table.
  Assumes an Avalon-MM master on the core clock and drop strobes and
  buffer usage from the buffer manager datapath on the same clock.
*/
`timescale 1ns/1ps
// Function
// R1: Count port 1 drops in 32 bits
// R2: Count port 2 drops in 32 bits
// R3: Count buffer, red and yellow drops
// R4: Read returns count and clears; reset zero
// R5: Counters saturate at all ones
// R6: Fabric reset starts table initialisation
// R7: Ready flag zero after reset, self-sets
// R8: Command write launches one table access; code ignores write-direction commands until the ready flag is set
// R9: Bit 4 selects read one, write zero
// R10: Bits 3:0 choose one of sixteen entries
// R11: Entry index follows buffer usage bands
// R12: Read command loads entry into read data
// R13: Host loads write data before command
// R14: Entries hold ten-bit probability per 1024
// R15: Host initialises table; reset does not
// R16: Read data holds until next read
module bmd_regs
  import bmd_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [BMD_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire bmd_drop_t port1_drop,
  input wire bmd_drop_t port2_drop,
  input wire logic [7:0] port_buffer_usage,
  output logic [9:0] usage_discard_prob,
  output logic tables_initialised_flag
);

  // ---------------------------------------------------------------
  // Bus request decode
  // ---------------------------------------------------------------
  bmd_req_t req;
  logic accepted;
  logic [31:0] read_word;
  logic [31:0] port1_count;
  logic [31:0] port2_count;
  logic [4:0] discard_table_command;
  logic [9:0] discard_table_write_data;
  logic [9:0] discard_table_read_data;
  logic [9:0] table_read_prob;
  logic [6:0] init_count;
  bmd_state_t state;
  bmd_state_t next_state;

  // Request fields gathered into one carrier
  assign req.address = avs_address;
  assign req.read = avs_read;
  assign req.write = avs_write;
  assign req.writedata = avs_writedata;

  // Byte address over four gives the register index
  wire logic [12:0] word_index = req.address[BMD_ADDR_W-1:2];
  wire logic aligned = (req.address[1:0] == 2'h 0);
  wire logic sel_p1 = aligned && (word_index == BMD_IDX_PORT1_DROP);
  wire logic sel_p2 = aligned && (word_index == BMD_IDX_PORT2_DROP);
  wire logic sel_status = aligned && (word_index == BMD_IDX_INIT_STATUS);
  wire logic sel_cmd = aligned && (word_index == BMD_IDX_TABLE_CMD);
  wire logic sel_wdata = aligned && (word_index == BMD_IDX_TABLE_WDATA);
  wire logic sel_rdata = aligned && (word_index == BMD_IDX_TABLE_RDATA);
  wire logic mapped = sel_p1 | sel_p2 | sel_status | sel_cmd | sel_wdata | sel_rdata;

  // Each request is answered one cycle after it is seen
  wire logic request = (req.read | req.write) && !accepted;
  wire logic do_read = request && req.read;
  wire logic do_write = request && req.write && !req.read;
  wire logic full_word = (avs_byteenable == 4'h f);

  // Side effects of accepted accesses
  wire logic clr_p1 = do_read && sel_p1; // [R4]
  wire logic clr_p2 = do_read && sel_p2; // [R4]
  wire logic wr_cmd = do_write && sel_cmd && full_word; // [R8]
  wire logic wr_wdata = do_write && sel_wdata && full_word;
  wire logic cmd_is_read = req.writedata[BMD_CMD_DIR_BIT]; // [R9]
  wire logic [3:0] cmd_index = req.writedata[BMD_CMD_IDX_MSB:0]; // [R10]
  wire logic table_write = wr_cmd && !cmd_is_read && (state == BMD_ST_READY); // [R8] [R9]
  wire logic table_read = wr_cmd && cmd_is_read; // [R12]

  // ---------------------------------------------------------------
  // Drop counters
  // ---------------------------------------------------------------
  bmd_drop_counter u_port1_counter (
    .clock(clock),
    .arst_n(arst_n),
    .drop(port1_drop),
    .clear(clr_p1),
    .count(port1_count)
  ); // [R1]

  bmd_drop_counter u_port2_counter (
    .clock(clock),
    .arst_n(arst_n),
    .drop(port2_drop),
    .clear(clr_p2),
    .count(port2_count)
  ); // [R2]

  // ---------------------------------------------------------------
  // Weight table and usage band lookup
  // ---------------------------------------------------------------
  // Bands of 8 up to 63, of 16 up to 127, of 32 up to 255
  wire logic [3:0] usage_index =
    (port_buffer_usage < 8'h 40) ? {1'b0, port_buffer_usage[5:3]} :
    (port_buffer_usage < 8'h 80) ? {2'b10, port_buffer_usage[5:4]} :
                                   {2'b11, port_buffer_usage[6:5]}; // [R11]
  wire logic [9:0] usage_prob_raw;
  wire logic [9:0] next_usage_prob = (state == BMD_ST_READY) ? usage_prob_raw : BMD_PROB_RESET;

  bmd_weight_table u_weight_table (
    .clock(clock),
    .write_en(table_write),
    .write_index(cmd_index),
    .write_prob(discard_table_write_data),
    .read_index(cmd_index),
    .read_prob(table_read_prob),
    .usage_index(usage_index),
    .usage_prob(usage_prob_raw)
  ); // [R14] [R15]

  // ---------------------------------------------------------------
  // Initialisation after fabric reset
  // ---------------------------------------------------------------
  // Count up to BMD_INIT_COUNT cycles, then declare ready
  always_comb begin
    case (state)
      BMD_ST_INIT: next_state = (init_count == BMD_INIT_COUNT) ? BMD_ST_READY : BMD_ST_INIT;
      BMD_ST_READY: next_state = BMD_ST_READY;
      default: next_state = BMD_ST_INIT;
    endcase
  end

  wire logic [6:0] next_init_count = (state == BMD_ST_INIT) ? init_count + 7'h 1 : init_count;

  // Init sequencer state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= BMD_ST_INIT; // [R6]
      init_count <= 7'h 00;
    end else begin
      state <= next_state;
      init_count <= next_init_count;
    end
  end

  assign tables_initialised_flag = (state == BMD_ST_READY); // [R7]

  // Cycles since reset release, watched by the ready timing check
  logic [7:0] since_reset;
  wire logic [7:0] next_since_reset =
    (since_reset == 8'h ff) ? since_reset : since_reset + 8'h 01;

  // Free-running, stops at its top value
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      since_reset <= 8'h 00;
    end else begin
      since_reset <= next_since_reset;
    end
  end

  // ---------------------------------------------------------------
  // Software-visible registers
  // ---------------------------------------------------------------
  // Command, write data and read data holding registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      discard_table_command <= BMD_CMD_RESET; // [R9] [R10]
      discard_table_write_data <= BMD_PROB_RESET;
      discard_table_read_data <= BMD_PROB_RESET;
    end else begin
      if (wr_cmd) begin
        discard_table_command <= req.writedata[BMD_CMD_DIR_BIT:0];
      end
      if (wr_wdata) begin
        discard_table_write_data <= req.writedata[BMD_PROB_W-1:0];
      end
      if (table_read) begin
        discard_table_read_data <= table_read_prob; // [R12] [R16]
      end
    end
  end

  // Read multiplexer
  assign read_word =
    sel_p1 ? port1_count :
    sel_p2 ? port2_count :
    sel_status ? {31'h 0, tables_initialised_flag} :
    sel_cmd ? {27'h 0, discard_table_command} :
    sel_wdata ? {22'h 0, discard_table_write_data} :
    sel_rdata ? {22'h 0, discard_table_read_data} : 32'h 0;

  // Answer registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      accepted <= 1'b0;
      avs_readdata <= 32'h 0;
      avs_response <= 2'h 0;
      usage_discard_prob <= BMD_PROB_RESET;
    end else begin
      accepted <= request;
      usage_discard_prob <= next_usage_prob;
      if (do_read) begin
        avs_readdata <= read_word;
      end
      if (request) begin
        avs_response <= mapped ? 2'h 0 : 2'h 3;
      end
    end
  end

  // Hold waitrequest until the registered answer stands
  assign avs_waitrequest = (avs_read | avs_write) && !accepted;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_read_cmd;
    wr_cmd && cmd_is_read;
  endsequence

  sequence s_rdata_loaded;
    discard_table_read_data == $past(table_read_prob);
  endsequence

  a_read_loads: assert property (@(posedge clock) disable iff (!arst_n) // [R12]
    s_read_cmd |=> s_rdata_loaded)
    else $error("Read command did not load read data");

  a_rdata_holds: assert property (@(posedge clock) disable iff (!arst_n) // [R16]
    !table_read |=> $stable(discard_table_read_data))
    else $error("Read data changed without a read command");

  a_ready_after: assert property (@(posedge clock) disable iff (!arst_n) // [R7]
    $rose(tables_initialised_flag) |-> $past(init_count) == BMD_INIT_COUNT)
    else $error("Ready flag set at the wrong time");

  a_ready_sticky: assert property (@(posedge clock) disable iff (!arst_n) // [R6]
    tables_initialised_flag |=> tables_initialised_flag)
    else $error("Ready flag dropped without reset");

  a_cmd_store: assert property (@(posedge clock) disable iff (!arst_n) // [R8]
    wr_cmd |=> discard_table_command == $past(req.writedata[4:0]))
    else $error("Command write not stored");

  a_band_upper: assert property (@(posedge clock) disable iff (!arst_n) // [R11]
    (port_buffer_usage >= 8'h e0) |-> usage_index == 4'h f)
    else $error("Top usage band mapped wrongly");

  a_wait_answer: assert property (@(posedge clock) disable iff (!arst_n)
    (avs_read && avs_waitrequest) |=> !avs_waitrequest)
    else $error("Read not answered in one cycle");

  a_table_write: assert property (@(posedge clock) disable iff (!arst_n) // [R9]
    (wr_cmd && cmd_is_read) |-> !table_write)
    else $error("Read command wrote the table");

  a_clear_p1: assert property (@(posedge clock) disable iff (!arst_n) // [R4]
    clr_p1 |=> (port1_count <= 32'h 1))
    else $error("Port 1 counter not cleared by read");

  a_clear_p2: assert property (@(posedge clock) disable iff (!arst_n) // [R4]
    clr_p2 |=> (port2_count <= 32'h 1))
    else $error("Port 2 counter not cleared by read");

  a_read_p1: assert property (@(posedge clock) disable iff (!arst_n) // [R1] [R4]
    clr_p1 |=> (avs_readdata == $past(port1_count)))
    else $error("Port 1 read did not return the count");

  a_read_p2: assert property (@(posedge clock) disable iff (!arst_n) // [R2] [R4]
    clr_p2 |=> (avs_readdata == $past(port2_count)))
    else $error("Port 2 read did not return the count");

  a_status_word: assert property (@(posedge clock) disable iff (!arst_n) // [R7]
    (do_read && sel_status) |=> (avs_readdata == {31'h 0, $past(tables_initialised_flag)}))
    else $error("Status read returned a wrong word");

  a_rdata_word: assert property (@(posedge clock) disable iff (!arst_n) // [R12]
    (do_read && sel_rdata) |=> (avs_readdata == {22'h 0, $past(discard_table_read_data)}))
    else $error("Table read data returned a wrong word");

  a_cmd_word: assert property (@(posedge clock) disable iff (!arst_n) // [R10]
    (do_read && sel_cmd) |=> (avs_readdata == {27'h 0, $past(discard_table_command)}))
    else $error("Command read returned a wrong word");

  a_wdata_store: assert property (@(posedge clock) disable iff (!arst_n) // [R14]
    wr_wdata |=> (discard_table_write_data == $past(req.writedata[9:0])))
    else $error("Write data not stored");

  a_unmapped_err: assert property (@(posedge clock) disable iff (!arst_n)
    (request && !mapped) |=> (avs_response == 2'h 3))
    else $error("Unmapped access not flagged");

  a_mapped_ok: assert property (@(posedge clock) disable iff (!arst_n)
    (request && mapped) |=> (avs_response == 2'h 0))
    else $error("Mapped access flagged as error");

  a_write_answer: assert property (@(posedge clock) disable iff (!arst_n)
    (avs_write && avs_waitrequest) |=> !avs_waitrequest)
    else $error("Write not answered in one cycle");

  a_partial_ignored: assert property (@(posedge clock) disable iff (!arst_n)
    (do_write && !full_word) |=>
      ($stable(discard_table_command) && $stable(discard_table_write_data)))
    else $error("Partial write changed a register");

  a_init_prob_zero: assert property (@(posedge clock) disable iff (!arst_n)
    !tables_initialised_flag |=> (usage_discard_prob == BMD_PROB_RESET))
    else $error("Usage probability shown before ready");

  a_band_low: assert property (@(posedge clock) disable iff (!arst_n) // [R11]
    (port_buffer_usage < 8'h 08) |-> (usage_index == 4'h 0))
    else $error("Lowest usage band mapped wrongly");

  a_band_mid: assert property (@(posedge clock) disable iff (!arst_n) // [R11]
    (port_buffer_usage[7:4] == 4'h 4) |-> (usage_index == 4'h 8))
    else $error("First sixteen-wide band mapped wrongly");

  a_band_edge: assert property (@(posedge clock) disable iff (!arst_n) // [R11]
    (port_buffer_usage[7:5] == 3'h 4) |-> (usage_index == 4'h c))
    else $error("First thirty-two-wide band mapped wrongly");

  a_write_lands: assert property (@(posedge clock) disable iff (!arst_n) // [R8]
    (wr_cmd && !cmd_is_read && tables_initialised_flag) |-> table_write)
    else $error("Write command did not reach the table");

  a_flag_in_reset: assert property (@(posedge clock) // [R7]
    !arst_n |-> !tables_initialised_flag)
    else $error("Ready flag set during reset");

  a_ready_time: assert property (@(posedge clock) disable iff (!arst_n) // [R6] [R7]
    tables_initialised_flag == (since_reset > 8'(BMD_INIT_CYCLES)))
    else $error("Ready flag timing wrong after reset");

endmodule : bmd_regs

// ### verif/test_bmd_regs.sv
/*
  Self-checking bench for the buffer manager register bank: bus tasks,
  drop counting, ready flag, indirect weight table and usage lookup.
  Assumes one core clock and a single-cycle-wait Avalon-MM slave.
*/
`timescale 1ns/1ps
module test_bmd_regs;
  import bmd_pkg::*;

  // ---------------------------------------------------------------
  // Signals and counters
  // ---------------------------------------------------------------
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [BMD_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  bmd_drop_t port1_drop = '0;
  bmd_drop_t port2_drop = '0;
  logic [7:0] port_buffer_usage = '0;
  logic [9:0] usage_discard_prob;
  logic tables_initialised_flag;
  int err_count = 0;
  int n_checks = 0;
  logic [9:0] prob [16];
  logic [31:0] d;
  logic [1:0] r;
  int ulist [12] = '{0, 7, 8, 63, 64, 79, 80, 127, 128, 159, 224, 255};

  bmd_regs bmd_regs_inst (
    .clock(clock), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .port1_drop(port1_drop), .port2_drop(port2_drop),
    .port_buffer_usage(port_buffer_usage), .usage_discard_prob(usage_discard_prob),
    .tables_initialised_flag(tables_initialised_flag)
  );

  // Core clock, 5 ns period
  initial begin
    forever #2.5 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [12:0] idx, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic [1:0] resp);
    int i;
    @(posedge clock);
    avs_address <= BMD_ADDR_W'({idx, 2'b00});
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= wdata;
    rdata = '0;
    resp = '0;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      err_count++;
      test_done();
    end
    rdata = avs_readdata;
    resp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [12:0] idx, input logic [31:0] wdata);
    logic [31:0] x;
    logic [1:0] y;
    bus(1'b1, idx, wdata, x, y);
  endtask : wr

  task automatic chkrd(input logic [12:0] idx, input logic [31:0] exp, input string msg);
    logic [31:0] x;
    logic [1:0] y;
    bus(1'b0, idx, '0, x, y);
    chk(x, exp, msg);
    chk(32'(y), 32'h0, "response");
  endtask : chkrd

  task automatic do_reset;
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
  endtask : do_reset

  task automatic wait_ready;
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clock);
      if (tables_initialised_flag === 1'b1) break;
    end
    if (i == 300) begin
      err_count++;
      test_done();
    end
  endtask : wait_ready

  // Usage band to table entry
  function automatic int band(input int u);
    if (u < 64) return u / 8;
    if (u < 128) return 8 + (u - 64) / 16;
    return 12 + (u - 128) / 32;
  endfunction : band

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 16; i++) prob[i] = 10'(i * 61 + 5);
    do_reset();
    chkrd(BMD_IDX_INIT_STATUS, 32'h0, "status after reset");
    chkrd(BMD_IDX_PORT1_DROP, 32'h0, "port1 reset");
    chkrd(BMD_IDX_PORT2_DROP, 32'h0, "port2 reset");
    chkrd(BMD_IDX_TABLE_CMD, 32'h0, "command reset");
    wait_ready();
    chkrd(BMD_IDX_INIT_STATUS, 32'h1, "status ready");
    wr(BMD_IDX_INIT_STATUS, 32'h0);
    chkrd(BMD_IDX_INIT_STATUS, 32'h1, "status read-only");
    // Drops of every cause, port 2 with all causes in one cycle
    for (int i = 0; i < 9; i++) begin
      @(posedge clock);
      port1_drop <= bmd_drop_t'(3'b001 << (i % 3));
      port2_drop <= (i < 5) ? bmd_drop_t'(3'b111) : bmd_drop_t'(3'b000);
    end
    @(posedge clock);
    port1_drop <= '0;
    port2_drop <= '0;
    chkrd(BMD_IDX_PORT1_DROP, 32'd9, "port1 count");
    chkrd(BMD_IDX_PORT2_DROP, 32'd5, "port2 count");
    chkrd(BMD_IDX_PORT1_DROP, 32'h0, "port1 cleared");
    chkrd(BMD_IDX_PORT2_DROP, 32'h0, "port2 cleared");
    // Load every entry, upper write bits set on purpose
    for (int i = 0; i < 16; i++) begin
      wr(BMD_IDX_TABLE_WDATA, 32'hffff_fc00 | 32'(prob[i]));
      wr(BMD_IDX_TABLE_CMD, 32'(i));
    end
    for (int i = 0; i < 16; i++) begin
      wr(BMD_IDX_TABLE_CMD, 32'h10 | 32'(i));
      chkrd(BMD_IDX_TABLE_RDATA, 32'(prob[i]), "entry read");
    end
    chkrd(BMD_IDX_TABLE_CMD, 32'h1f, "command readback");
    // Partial byte enables leave write data as it was
    avs_byteenable <= 4'h3;
    wr(BMD_IDX_TABLE_WDATA, 32'h155);
    avs_byteenable <= 4'hf;
    chkrd(BMD_IDX_TABLE_WDATA, 32'(prob[15]), "partial write ignored");
    // Read data survives a later write command
    wr(BMD_IDX_TABLE_CMD, 32'h15);
    wr(BMD_IDX_TABLE_WDATA, 32'h0);
    wr(BMD_IDX_TABLE_CMD, 32'h03);
    prob[3] = 10'h000;
    chkrd(BMD_IDX_TABLE_RDATA, 32'(prob[5]), "read data held");
    wr(BMD_IDX_TABLE_CMD, 32'h13);
    chkrd(BMD_IDX_TABLE_RDATA, 32'h0, "entry rewritten");
    // Usage band lookup at the band edges
    foreach (ulist[k]) begin
      @(posedge clock);
      port_buffer_usage <= 8'(ulist[k]);
      repeat (2) @(posedge clock);
      chk(32'(usage_discard_prob), 32'(prob[band(ulist[k])]), "usage band");
    end
    bus(1'b0, BMD_IDX_BASE + 13'h00f, '0, d, r);
    chk(d, 32'h0, "unmapped data");
    chk(32'(r), 32'h3, "unmapped response");
    // Reset in mid-run with a count pending
    @(posedge clock);
    port1_drop <= bmd_drop_t'(3'b100);
    @(posedge clock);
    port1_drop <= '0;
    do_reset();
    @(posedge clock);
    chk(32'(tables_initialised_flag), 32'h0, "flag after second reset");
    chkrd(BMD_IDX_PORT1_DROP, 32'h0, "port1 after second reset");
    chkrd(BMD_IDX_TABLE_CMD, 32'h0, "command after second reset");
    wait_ready();
    chkrd(BMD_IDX_INIT_STATUS, 32'h1, "ready again");
    test_done();
  end
endmodule : test_bmd_regs
